// ===== rtl/core_regs_pkg.sv
package core_regs_pkg;

  // memory-mapped locations of the index pointer halves
  localparam logic [7:0]  XPTR_HI_ADDR   = 8'hBE;
  localparam logic [7:0]  XPTR_LO_ADDR   = 8'hBF;

  // reset values
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [10:0] XPTR_RESET     = 11'h000;
  localparam logic [9:0]  PC_RESET       = 10'h000;
  localparam logic [3:0]  SP_RESET       = 4'hF;
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;

  // address spaces
  localparam logic [11:0] CODE_BASE      = 12'hC00;
  localparam logic [11:0] DATA_BASE      = 12'h000;
  localparam logic [3:0]  STACK_PAGE     = 4'h3;
  localparam int          XPTR_SPACE_BIT = 10;

  // stack pointer step per pushed or pulled address
  localparam logic [3:0]  SP_STEP        = 4'h2;
  localparam logic [3:0]  SP_ONE         = 4'h1;

  // condition flag positions
  localparam int          FLAG_C         = 0;
  localparam int          FLAG_H         = 1;
  localparam int          FLAG_Z         = 2;
  localparam int          FLAG_N         = 3;
  localparam int          FLAG_G         = 4;
  localparam int          FLAG_R         = 5;
  localparam logic [7:0]  FLAGS_USED     = 8'h3F;

  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_ALU      = 5'h01,
    OP_LOAD_C   = 5'h02,
    OP_INVERT_C = 5'h03,
    OP_SET_C    = 5'h04,
    OP_CLEAR_C  = 5'h05,
    OP_LOAD_X   = 5'h06,
    OP_INC_X    = 5'h07,
    OP_DEC_X    = 5'h08,
    OP_IDX_RD   = 5'h09,
    OP_IDX_WR   = 5'h0A,
    OP_CALL     = 5'h0B,
    OP_RETURN   = 5'h0C,
    OP_JUMP     = 5'h0D,
    OP_SET_G    = 5'h0E,
    OP_CLEAR_G  = 5'h0F,
    OP_LOAD_SP  = 5'h10,
    OP_LOAD_SR  = 5'h11
  } op_t;

  typedef enum logic [3:0] {
    ALU_ADD  = 4'h0,
    ALU_ADC  = 4'h1,
    ALU_SUBC = 4'h2,
    ALU_AND  = 4'h3,
    ALU_OR   = 4'h4,
    ALU_XOR  = 4'h5,
    ALU_LOAD = 4'h6,
    ALU_RLC  = 4'h7,
    ALU_RRC  = 4'h8,
    ALU_INC  = 4'h9,
    ALU_DEC  = 4'hA
  } alu_sel_t;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_PUSH_HI  = 5'b00010,
    ST_PULL_LO  = 5'b00100,
    ST_CAP_HI   = 5'b01000,
    ST_CAP_LO   = 5'b10000
  } stack_state_t;

endpackage : core_regs_pkg

// ===== rtl/flag_alu.sv
`timescale 1ns/1ns
module flag_alu (
  input  wire logic                   [3:0] sel_in,
  input  wire logic                   [7:0] acc_in,
  input  wire logic                   [7:0] operand_in,
  input  wire logic                         carry_in,
  output logic                        [7:0] result_out,
  output logic                              carry_out,
  output logic                              half_out,
  output logic                              zero_out,
  output logic                              neg_out,
  output logic                              upd_carry_out,
  output logic                              upd_half_out
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] sub_b;
  logic       cin;

  always_comb begin
    result_out    = acc_in;
    carry_out     = carry_in;
    half_out      = 1'b0;
    upd_carry_out = 1'b0;
    upd_half_out  = 1'b0;
    cin           = 1'b0;
    sub_b         = operand_in;
    sum           = 9'h000;
    nib           = 5'h00;
    case (sel_in)
      core_regs_pkg::ALU_ADD, core_regs_pkg::ALU_ADC,
      core_regs_pkg::ALU_SUBC: begin
        // subtract as add of complement; carry reads as borrow afterwards
        if (sel_in == core_regs_pkg::ALU_SUBC) begin
          sub_b = ~operand_in;
          cin   = ~carry_in;
        end else if (sel_in == core_regs_pkg::ALU_ADC) begin
          cin   = carry_in;
        end
        sum  = {1'b0, acc_in} + {1'b0, sub_b} + {8'h00, cin};
        nib  = {1'b0, acc_in[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, cin};
        result_out    = sum[7:0];
        upd_carry_out = 1'b1;
        upd_half_out  = 1'b1;
        if (sel_in == core_regs_pkg::ALU_SUBC) begin
          carry_out = ~sum[8]; // RQ12
          half_out  = ~nib[4]; // RQ13
        end else begin
          carry_out = sum[8]; // RQ12
          half_out  = nib[4]; // RQ13
        end
      end
      core_regs_pkg::ALU_AND:  result_out = acc_in & operand_in;
      core_regs_pkg::ALU_OR:   result_out = acc_in | operand_in;
      core_regs_pkg::ALU_XOR:  result_out = acc_in ^ operand_in;
      core_regs_pkg::ALU_LOAD: result_out = operand_in;
      core_regs_pkg::ALU_RLC: begin
        result_out    = {operand_in[6:0], carry_in}; // RQ12
        carry_out     = operand_in[7];
        upd_carry_out = 1'b1;
      end
      core_regs_pkg::ALU_RRC: begin
        result_out    = {carry_in, operand_in[7:1]}; // RQ12
        carry_out     = operand_in[0];
        upd_carry_out = 1'b1;
      end
      core_regs_pkg::ALU_INC:  result_out = operand_in + 8'h01;
      core_regs_pkg::ALU_DEC:  result_out = operand_in - 8'h01;
      default:                 result_out = acc_in;
    endcase
  end

  assign zero_out = (result_out == 8'h00); // RQ14
  assign neg_out  = result_out[7]; // RQ15

endmodule : flag_alu

// ===== rtl/cpu_core_register_set.sv
`timescale 1ns/1ns
// Summary of operation
// RQ1 - eight-bit accumulator holds operands and arithmetic or data results
// RQ2 - effective address is unsigned 8-bit offset plus the index pointer; in data space the code keeps only the sum's low eight bits
// RQ3 - indexed stores into code space are dropped; loads from it work
// RQ4 - index pointer high bits at 0xBE, low byte at 0xBF
// RQ5 - pointer top bit is write-only, selects data or code space
// RQ6 - pointer counting uses only the ten low bits
// RQ7 - ten-bit program counter starts at code address 0xC00 after reset
// RQ8 - four-bit stack pointer in RAM 0x30-0x3F, resets to 0xF
// RQ9 - stack pointer drops by two per push, rises by two per pull
// RQ10 - call pushes return address low byte first; return reloads it
// RQ11 - status register holds C, H, Z, N, G and write flag
// RQ12 - carry follows arithmetic carry or borrow; rotates go through it
// RQ13 - half carry marks overflow across the accumulator nibble boundary
// RQ14 - zero flag set for a zero result, cleared otherwise
// RQ15 - negative flag copies the result's top bit
// RQ16 - carry can be loaded from a chosen bit or inverted
// RQ17 - interrupt mask is clear after reset; only software sets it
// RQ18 - stack RAM address is window base with pointer in low nibble
module cpu_core_register_set (
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  input  wire logic                   op_valid_in,
  input  wire logic             [4:0] op_code_in,
  input  wire logic             [3:0] alu_sel_in,
  input  wire logic             [7:0] operand_in,
  input  wire logic             [2:0] bit_sel_in,
  input  wire logic            [10:0] xptr_value_in,
  input  wire logic             [9:0] target_in,
  input  wire logic                   pc_step_in,
  input  wire logic                   mmio_wr_in,
  input  wire logic                   mmio_rd_in,
  input  wire logic             [7:0] mmio_addr_in,
  input  wire logic             [7:0] mmio_wdata_in,
  input  wire logic             [7:0] stack_rdata_in,
  output logic                  [7:0] mmio_rdata_out,
  output logic                        mmio_hit_out,
  output logic                 [11:0] ea_addr_out,
  output logic                        ea_rd_out,
  output logic                        ea_wr_out,
  output logic                  [7:0] stack_addr_out,
  output logic                  [7:0] stack_wdata_out,
  output logic                        stack_wr_out,
  output logic                        stack_rd_out,
  output logic                 [11:0] instr_addr_out,
  output logic                  [7:0] acc_out,
  output logic                 [10:0] xptr_out,
  output logic                  [3:0] stack_ptr_out,
  output logic                  [7:0] condition_flags_out,
  output logic                        busy_out
);

  function automatic logic [7:0] stack_ram_addr(input logic [3:0] ptr);
    stack_ram_addr = {core_regs_pkg::STACK_PAGE, ptr}; // RQ18
  endfunction : stack_ram_addr

  logic                         [7:0] acc_r;
  logic                         [7:0] acc_nxt;
  logic                        [10:0] xptr_r;
  logic                        [10:0] xptr_nxt;
  logic                         [9:0] instr_pointer_r;
  logic                         [9:0] instr_pointer_nxt;
  logic                         [3:0] stack_ptr_r;
  logic                         [3:0] stack_ptr_nxt;
  logic                         [7:0] flags_r;
  logic                         [7:0] flags_nxt;
  logic                         [1:0] ret_hi_r;
  logic                         [1:0] ret_hi_nxt;
  logic                         [9:0] call_target_r;
  logic                         [9:0] call_target_nxt;
  core_regs_pkg::stack_state_t        state_r;
  core_regs_pkg::stack_state_t        state_nxt;
  logic                         [7:0] stack_addr_r;
  logic                         [7:0] stack_addr_nxt;
  logic                         [7:0] stack_wdata_r;
  logic                         [7:0] stack_wdata_nxt;
  logic                               stack_wr_r;
  logic                               stack_wr_nxt;
  logic                               stack_rd_r;
  logic                               stack_rd_nxt;
  logic                        [11:0] ea_addr_r;
  logic                               ea_rd_r;
  logic                               ea_wr_r;
  logic                         [7:0] mmio_rdata_r;
  logic                               mmio_hit_r;

  logic                         [7:0] alu_result;
  logic                               alu_carry;
  logic                               alu_half;
  logic                               alu_zero;
  logic                               alu_neg;
  logic                               alu_upd_c;
  logic                               alu_upd_h;

  localparam logic [3:0] SP_ONE_W = core_regs_pkg::SP_ONE;
  wire        idle        = (state_r == core_regs_pkg::ST_IDLE);
  // new operations are only taken while the stack sequencer is idle
  wire        op_take     = op_valid_in & idle;
  wire        op_is_alu   = op_take & (op_code_in == core_regs_pkg::OP_ALU);
  wire        op_is_idxrd = op_take & (op_code_in == core_regs_pkg::OP_IDX_RD);
  wire        op_is_idxwr = op_take & (op_code_in == core_regs_pkg::OP_IDX_WR);
  wire        op_touch_x  = op_take &
                            ((op_code_in == core_regs_pkg::OP_LOAD_X) |
                             (op_code_in == core_regs_pkg::OP_INC_X) |
                             (op_code_in == core_regs_pkg::OP_DEC_X));
  wire        sel_hi      = (mmio_addr_in == core_regs_pkg::XPTR_HI_ADDR);
  wire        sel_lo      = (mmio_addr_in == core_regs_pkg::XPTR_LO_ADDR);
  wire        code_space  = xptr_r[core_regs_pkg::XPTR_SPACE_BIT]; // RQ5
  wire [9:0]  ea_sum      = xptr_r[9:0] + {2'b00, operand_in}; // RQ2
  wire [11:0] ea_addr     = code_space ?
                            (core_regs_pkg::CODE_BASE | {2'b00, ea_sum}) :
                            (core_regs_pkg::DATA_BASE |
                             {4'h0, ea_sum[7:0]}); // RQ5
  // the space bit reads back as zero: it is write-only
  wire [7:0]  xhi_read    = {5'b00000, 1'b0, xptr_r[9:8]}; // RQ5
  wire [7:0]  mmio_read   = sel_hi ? xhi_read :
                            (sel_lo ? xptr_r[7:0] : 8'h00); // RQ4

  flag_alu u_flag_alu (
    .sel_in        (alu_sel_in),
    .acc_in        (acc_r),
    .operand_in    (operand_in),
    .carry_in      (flags_r[core_regs_pkg::FLAG_C]),
    .result_out    (alu_result),
    .carry_out     (alu_carry),
    .half_out      (alu_half),
    .zero_out      (alu_zero),
    .neg_out       (alu_neg),
    .upd_carry_out (alu_upd_c),
    .upd_half_out  (alu_upd_h)
  );

  // accumulator and condition flags
  always_comb begin
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    if (op_is_alu) begin
      acc_nxt = alu_result; // RQ1
      flags_nxt[core_regs_pkg::FLAG_Z] = alu_zero; // RQ14
      flags_nxt[core_regs_pkg::FLAG_N] = alu_neg; // RQ15
      if (alu_upd_c) begin
        flags_nxt[core_regs_pkg::FLAG_C] = alu_carry; // RQ12
      end
      if (alu_upd_h) begin
        flags_nxt[core_regs_pkg::FLAG_H] = alu_half; // RQ13
      end
    end else if (op_take) begin
      case (op_code_in)
        core_regs_pkg::OP_LOAD_C:
          flags_nxt[core_regs_pkg::FLAG_C] = operand_in[bit_sel_in]; // RQ16
        core_regs_pkg::OP_INVERT_C:
          flags_nxt[core_regs_pkg::FLAG_C] =
            ~flags_r[core_regs_pkg::FLAG_C]; // RQ16
        core_regs_pkg::OP_SET_C:   flags_nxt[core_regs_pkg::FLAG_C] = 1'b1;
        core_regs_pkg::OP_CLEAR_C: flags_nxt[core_regs_pkg::FLAG_C] = 1'b0;
        core_regs_pkg::OP_SET_G:   flags_nxt[core_regs_pkg::FLAG_G] = 1'b1;
        core_regs_pkg::OP_CLEAR_G: flags_nxt[core_regs_pkg::FLAG_G] = 1'b0;
        core_regs_pkg::OP_LOAD_SR:
          flags_nxt = operand_in & core_regs_pkg::FLAGS_USED; // RQ11
        default: flags_nxt = flags_r;
      endcase
    end
  end

  // index pointer: core operations win over a same-cycle mapped write
  always_comb begin
    xptr_nxt = xptr_r;
    if (op_touch_x) begin
      case (op_code_in)
        core_regs_pkg::OP_LOAD_X: xptr_nxt = xptr_value_in;
        core_regs_pkg::OP_INC_X:
          xptr_nxt[9:0] = xptr_r[9:0] + 10'h001; // RQ6
        core_regs_pkg::OP_DEC_X:
          xptr_nxt[9:0] = xptr_r[9:0] - 10'h001; // RQ6
        default: xptr_nxt = xptr_r;
      endcase
    end else if (mmio_wr_in & sel_hi) begin
      xptr_nxt[10:8] = mmio_wdata_in[2:0]; // RQ4
    end else if (mmio_wr_in & sel_lo) begin
      xptr_nxt[7:0] = mmio_wdata_in; // RQ4
    end
  end

  // program counter, stack pointer and call/return sequencer
  always_comb begin
    instr_pointer_nxt = instr_pointer_r;
    stack_ptr_nxt     = stack_ptr_r;
    state_nxt         = state_r;
    ret_hi_nxt        = ret_hi_r;
    call_target_nxt   = call_target_r;
    stack_addr_nxt    = stack_addr_r;
    stack_wdata_nxt   = stack_wdata_r;
    stack_wr_nxt      = 1'b0;
    stack_rd_nxt      = 1'b0;
    case (state_r)
      core_regs_pkg::ST_IDLE: begin
        if (op_take && op_code_in == core_regs_pkg::OP_CALL) begin
          stack_addr_nxt  = stack_ram_addr(stack_ptr_r);
          stack_wdata_nxt = instr_pointer_r[7:0]; // RQ10
          stack_wr_nxt    = 1'b1;
          call_target_nxt = target_in;
          state_nxt       = core_regs_pkg::ST_PUSH_HI;
        end else if (op_take && op_code_in == core_regs_pkg::OP_RETURN) begin
          // last byte pushed was the high one, so it comes back first
          stack_addr_nxt = stack_ram_addr(stack_ptr_r + SP_ONE_W);
          stack_rd_nxt   = 1'b1; // RQ10
          state_nxt      = core_regs_pkg::ST_PULL_LO;
        end else if (op_take && op_code_in == core_regs_pkg::OP_JUMP) begin
          instr_pointer_nxt = target_in;
        end else if (op_take && op_code_in == core_regs_pkg::OP_LOAD_SP) begin
          stack_ptr_nxt = operand_in[3:0]; // RQ8
        end else if (pc_step_in) begin
          instr_pointer_nxt = instr_pointer_r + 10'h001; // RQ7
        end
      end
      core_regs_pkg::ST_PUSH_HI: begin
        stack_addr_nxt    = stack_ram_addr(stack_ptr_r - SP_ONE_W);
        stack_wdata_nxt   = {6'b000000, instr_pointer_r[9:8]}; // RQ10
        stack_wr_nxt      = 1'b1;
        stack_ptr_nxt     = stack_ptr_r - core_regs_pkg::SP_STEP; // RQ9
        instr_pointer_nxt = call_target_r;
        state_nxt         = core_regs_pkg::ST_IDLE;
      end
      core_regs_pkg::ST_PULL_LO: begin
        stack_addr_nxt = stack_ram_addr(stack_ptr_r + core_regs_pkg::SP_STEP);
        stack_rd_nxt   = 1'b1;
        state_nxt      = core_regs_pkg::ST_CAP_HI;
      end
      core_regs_pkg::ST_CAP_HI: begin
        ret_hi_nxt = stack_rdata_in[1:0];
        state_nxt  = core_regs_pkg::ST_CAP_LO;
      end
      core_regs_pkg::ST_CAP_LO: begin
        instr_pointer_nxt = {ret_hi_r, stack_rdata_in}; // RQ10
        stack_ptr_nxt     = stack_ptr_r + core_regs_pkg::SP_STEP; // RQ9
        state_nxt         = core_regs_pkg::ST_IDLE;
      end
      default: state_nxt = core_regs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      acc_r           <= core_regs_pkg::ACC_RESET;
      xptr_r          <= core_regs_pkg::XPTR_RESET;
      instr_pointer_r <= core_regs_pkg::PC_RESET; // RQ7
      stack_ptr_r     <= core_regs_pkg::SP_RESET; // RQ8
      flags_r         <= core_regs_pkg::FLAGS_RESET; // RQ17
      state_r         <= core_regs_pkg::ST_IDLE;
    end else begin
      acc_r           <= acc_nxt;
      xptr_r          <= xptr_nxt;
      instr_pointer_r <= instr_pointer_nxt;
      stack_ptr_r     <= stack_ptr_nxt;
      flags_r         <= flags_nxt;
      state_r         <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ret_hi_r      <= 2'b00;
      call_target_r <= 10'h000;
      stack_addr_r  <= 8'h00;
      stack_wdata_r <= 8'h00;
      stack_wr_r    <= 1'b0;
      stack_rd_r    <= 1'b0;
    end else begin
      ret_hi_r      <= ret_hi_nxt;
      call_target_r <= call_target_nxt;
      stack_addr_r  <= stack_addr_nxt;
      stack_wdata_r <= stack_wdata_nxt;
      stack_wr_r    <= stack_wr_nxt;
      stack_rd_r    <= stack_rd_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ea_addr_r    <= 12'h000;
      ea_rd_r      <= 1'b0;
      ea_wr_r      <= 1'b0;
      mmio_rdata_r <= 8'h00;
      mmio_hit_r   <= 1'b0;
    end else begin
      if (op_is_idxrd | op_is_idxwr) begin
        ea_addr_r <= ea_addr; // RQ2
      end
      ea_rd_r      <= op_is_idxrd;
      // code space cannot be written through the pointer
      ea_wr_r      <= op_is_idxwr & ~code_space; // RQ3
      mmio_hit_r   <= (mmio_rd_in | mmio_wr_in) & (sel_hi | sel_lo);
      if (mmio_rd_in) begin
        mmio_rdata_r <= mmio_read; // RQ4
      end
    end
  end

  assign mmio_rdata_out      = mmio_rdata_r;
  assign mmio_hit_out        = mmio_hit_r;
  assign ea_addr_out         = ea_addr_r;
  assign ea_rd_out           = ea_rd_r;
  assign ea_wr_out           = ea_wr_r;
  assign stack_addr_out      = stack_addr_r;
  assign stack_wdata_out     = stack_wdata_r;
  assign stack_wr_out        = stack_wr_r;
  assign stack_rd_out        = stack_rd_r;
  // the counter holds ten bits; fetches always land in code space
  assign instr_addr_out      = core_regs_pkg::CODE_BASE |
                               {2'b00, instr_pointer_r}; // RQ7
  assign acc_out             = acc_r;
  assign xptr_out            = xptr_r;
  assign stack_ptr_out       = stack_ptr_r;
  assign condition_flags_out = flags_r; // RQ11
  assign busy_out            = ~idle;

endmodule : cpu_core_register_set

// ===== dv/core_regs_monitor.sv
`timescale 1ns/1ns
module core_regs_monitor (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        op_valid_in,
  input  wire logic  [4:0] op_code_in,
  input  wire logic        mmio_rd_in,
  input  wire logic  [7:0] mmio_addr_in,
  input  wire logic  [7:0] mmio_rdata_out,
  input  wire logic [11:0] ea_addr_out,
  input  wire logic        ea_wr_out,
  input  wire logic  [7:0] stack_addr_out,
  input  wire logic  [7:0] stack_wdata_out,
  input  wire logic        stack_wr_out,
  input  wire logic        stack_rd_out,
  input  wire logic [11:0] instr_addr_out,
  input  wire logic  [7:0] acc_out,
  input  wire logic [10:0] xptr_out,
  input  wire logic  [3:0] stack_ptr_out,
  input  wire logic  [7:0] condition_flags_out,
  input  wire logic        busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire       take_w  = op_valid_in && !busy_out;
  wire [7:0] pc_lo_w = instr_addr_out[7:0];
  wire       carry_w = condition_flags_out[0];
  wire       mask_w  = condition_flags_out[4];
  wire       top_w   = xptr_out[10];
  sequence call_s;
    take_w && op_code_in == core_regs_pkg::OP_CALL;
  endsequence
  sequence ret_s;
    take_w && op_code_in == core_regs_pkg::OP_RETURN;
  endsequence
  reset_vals_a: assert property ($fell(reset_in) |->
    stack_ptr_out == 4'hF && condition_flags_out == 8'h00 &&
    instr_addr_out == 12'hC00) else $error("reset values wrong");
  code_store_a: assert property (ea_wr_out |->
    ea_addr_out[11:8] == 4'h0) else $error("store into code space");
  space_map_a: assert property (ea_addr_out[11:8] == 4'h0 ||
    ea_addr_out[11:10] == 2'b11) else $error("address outside spaces");
  fetch_space_a: assert property (instr_addr_out[11:10] == 2'b11)
    else $error("fetch outside code space");
  call_push_a: assert property (call_s |=> stack_wr_out &&
    stack_addr_out == {4'h3, $past(stack_ptr_out)} &&
    stack_wdata_out == $past(pc_lo_w) ##1 stack_wr_out &&
    stack_addr_out == {4'h3, $past(stack_ptr_out, 2) - 4'h1} &&
    stack_ptr_out == $past(stack_ptr_out, 2) - 4'h2)
    else $error("call push sequence wrong");
  ret_pull_a: assert property (ret_s |=> stack_rd_out &&
    stack_addr_out == {4'h3, $past(stack_ptr_out) + 4'h1} ##1
    stack_rd_out ##1 !stack_rd_out ##1 !busy_out &&
    stack_ptr_out == $past(stack_ptr_out, 4) + 4'h2)
    else $error("return pull sequence wrong");
  carry_inv_a: assert property (take_w &&
    op_code_in == core_regs_pkg::OP_INVERT_C |=> carry_w == !$past(carry_w))
    else $error("carry not inverted");
  zero_neg_a: assert property (take_w &&
    op_code_in == core_regs_pkg::OP_ALU |=>
    condition_flags_out[2] == (acc_out == 8'h00) &&
    condition_flags_out[3] == acc_out[7]) else $error("z or n flag wrong");
  mask_set_a: assert property ($rose(mask_w) |-> $past(take_w) &&
    ($past(op_code_in) == core_regs_pkg::OP_SET_G ||
    $past(op_code_in) == core_regs_pkg::OP_LOAD_SR))
    else $error("mask set without instruction");
  xhi_read_a: assert property (mmio_rd_in &&
    mmio_addr_in == core_regs_pkg::XPTR_HI_ADDR |=>
    mmio_rdata_out[7:2] == 6'h00) else $error("space bit readable");
  xptr_top_a: assert property (take_w &&
    (op_code_in == core_regs_pkg::OP_INC_X ||
    op_code_in == core_regs_pkg::OP_DEC_X) |=> top_w == $past(top_w))
    else $error("count touched space bit");
endmodule : core_regs_monitor
bind cpu_core_register_set core_regs_monitor core_regs_monitor_inst (
  .clk_sys_in, .reset_in, .op_valid_in, .op_code_in, .mmio_rd_in,
  .mmio_addr_in, .mmio_rdata_out, .ea_addr_out, .ea_wr_out,
  .stack_addr_out, .stack_wdata_out, .stack_wr_out, .stack_rd_out,
  .instr_addr_out, .acc_out, .xptr_out, .stack_ptr_out,
  .condition_flags_out, .busy_out);

// ===== dv/cpu_core_register_set_tb_top.sv
`timescale 1ns/1ns
module cpu_core_register_set_tb_top;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, op_valid_in = 1'b0;
  logic pc_step_in = 1'b0, mmio_wr_in = 1'b0, mmio_rd_in = 1'b0;
  logic [4:0] op_code_in = 5'h00;
  logic [3:0] alu_sel_in = 4'h0;
  logic [2:0] bit_sel_in = 3'h0;
  logic [7:0] operand_in = 8'h00, mmio_addr_in = 8'h00;
  logic [7:0] mmio_wdata_in = 8'h00, stack_rdata_in = 8'h00;
  logic [10:0] xptr_value_in = 11'h000;
  logic [9:0] target_in = 10'h000;
  logic [7:0] mmio_rdata_out, stack_addr_out, stack_wdata_out, acc_out;
  logic [7:0] condition_flags_out;
  logic [11:0] ea_addr_out, instr_addr_out;
  logic [10:0] xptr_out;
  logic [3:0] stack_ptr_out;
  logic mmio_hit_out, ea_rd_out, ea_wr_out, stack_wr_out, stack_rd_out;
  logic busy_out;
  int failures = 0, samples_checked = 0, cycles = 0;
  cpu_core_register_set cpu_core_register_set_inst (.*);
  initial forever #50 clk_sys_in = ~clk_sys_in;
  // a hang in the stack handshake must still end the run
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic op(input core_regs_pkg::op_t c, input logic [7:0] d);
    // one idle edge between calls so valid is never lowered and raised at once
    @(posedge clk_sys_in) #1;
    op_code_in = c;
    operand_in = d;
    op_valid_in = 1'b1;
    @(posedge clk_sys_in) #1;
    op_valid_in = 1'b0;
  endtask : op
  task automatic mmio(input logic wr, input logic [7:0] a, d);
    @(posedge clk_sys_in) #1;
    mmio_wr_in = wr;
    mmio_rd_in = !wr;
    mmio_addr_in = a;
    mmio_wdata_in = d;
    @(posedge clk_sys_in) #1;
    mmio_wr_in = 1'b0;
    mmio_rd_in = 1'b0;
  endtask : mmio
  task automatic t_reset();
    chk(acc_out, 12'h000);
    chk(stack_ptr_out, 12'h00F);
    chk(condition_flags_out, 12'h000);
    chk(instr_addr_out, 12'hC00);
  endtask : t_reset
  task automatic t_alu();
    logic [3:0] s[5] = '{4'h6, 4'h0, 4'h0, 4'h2, 4'h7};
    logic [7:0] d[5] = '{8'h88, 8'h88, 8'hF0, 8'h01, 8'h80};
    logic [7:0] a[5] = '{8'h88, 8'h10, 8'h00, 8'hFE, 8'h01};
    logic [7:0] f[5] = '{8'h08, 8'h03, 8'h05, 8'h0B, 8'h03};
    for (int i = 0; i < 5; i++) begin
      alu_sel_in = s[i];
      op(core_regs_pkg::OP_ALU, d[i]);
      chk(acc_out, a[i]);
      chk(condition_flags_out, f[i]);
    end
  endtask : t_alu
  task automatic t_bits();
    bit_sel_in = 3'h2;
    op(core_regs_pkg::OP_LOAD_C, 8'hFB);
    chk(condition_flags_out[0], 12'h000);
    op(core_regs_pkg::OP_INVERT_C, 8'h00);
    chk(condition_flags_out[0], 12'h001);
    op(core_regs_pkg::OP_SET_G, 8'h00);
    chk(condition_flags_out[4], 12'h001);
    op(core_regs_pkg::OP_CLEAR_G, 8'h00);
    chk(condition_flags_out[4], 12'h000);
    op(core_regs_pkg::OP_LOAD_SR, 8'hFF);
    chk(condition_flags_out, 12'h03F);
  endtask : t_bits
  task automatic t_index();
    xptr_value_in = 11'h7F0;
    op(core_regs_pkg::OP_LOAD_X, 8'h00);
    op(core_regs_pkg::OP_IDX_RD, 8'h20);
    chk({ea_rd_out, ea_addr_out}, 13'h1C10);
    op(core_regs_pkg::OP_IDX_WR, 8'h20);
    chk(ea_wr_out, 12'h000);
    xptr_value_in = 11'h0F0;
    op(core_regs_pkg::OP_LOAD_X, 8'h00);
    op(core_regs_pkg::OP_IDX_WR, 8'h20);
    chk({ea_wr_out, ea_addr_out}, 13'h1010);
    xptr_value_in = 11'h7FF;
    op(core_regs_pkg::OP_LOAD_X, 8'h00);
    op(core_regs_pkg::OP_INC_X, 8'h00);
    chk(xptr_out, 12'h400);
  endtask : t_index
  task automatic t_mmio();
    mmio(1'b1, 8'hBE, 8'h05);
    mmio(1'b1, 8'hBF, 8'hA5);
    chk(xptr_out, 12'h5A5);
    mmio(1'b0, 8'hBE, 8'h00);
    chk({mmio_hit_out, mmio_rdata_out}, 12'h101);
    mmio(1'b0, 8'hBF, 8'h00);
    chk(mmio_rdata_out, 12'h0A5);
    mmio(1'b0, 8'h10, 8'h00);
    chk({mmio_hit_out, mmio_rdata_out}, 12'h000);
  endtask : t_mmio
  task automatic t_stack();
    target_in = 10'h2A5;
    op(core_regs_pkg::OP_JUMP, 8'h00);
    target_in = 10'h100;
    op(core_regs_pkg::OP_CALL, 8'h00);
    chk({stack_wr_out, stack_addr_out, stack_wdata_out}, 17'h13FA5);
    @(posedge clk_sys_in) #1;
    chk({stack_wr_out, stack_addr_out, stack_wdata_out}, 17'h13E02);
    chk({stack_ptr_out, instr_addr_out}, 16'hDD00);
    op(core_regs_pkg::OP_RETURN, 8'h00);
    chk({stack_rd_out, stack_addr_out}, 12'h13E);
    @(posedge clk_sys_in) #1;
    chk({stack_rd_out, stack_addr_out}, 12'h13F);
    // ram answers one cycle after each read strobe: high byte first
    stack_rdata_in = 8'h02;
    @(posedge clk_sys_in) #1;
    stack_rdata_in = 8'hA5;
    @(posedge clk_sys_in) #1;
    chk({stack_ptr_out, instr_addr_out}, 16'hFEA5);
    pc_step_in = 1'b1;
    @(posedge clk_sys_in) #1;
    pc_step_in = 1'b0;
    chk(instr_addr_out, 12'hEA6);
    op(core_regs_pkg::OP_LOAD_SP, 8'h37);
    chk(stack_ptr_out, 12'h007);
  endtask : t_stack
  initial begin
    repeat (4) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    @(posedge clk_sys_in) #1;
    t_reset();
    t_alu();
    t_bits();
    t_index();
    t_mmio();
    t_stack();
    test_done();
  end
endmodule : cpu_core_register_set_tb_top
